// ==== dpm_pkg.sv ====
// constants for the dual-port memory port controller, plus its synchroniser
// Summary of operation
// - memory read needs both chip select and output enable driven low.
// - token latch read uses token select instead of chip select, plus enable.
// - host delays writes until busy from the master has settled.
// - request token by writing zero, read back; zero owns, one keeps polling.
// - after a token write, strobes drop for a gap before reading back.
package dpm_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SYNC_STAGES   = 2;
   // device timing figures, plain defaults for the slowest speed grade
   localparam int ACCESS_NS     = 25;
   localparam int WRITE_PULSE_NS = 22;
   localparam int MATCH_FLAG_NS = 20;  // match_to_flag_delay
   localparam int SELECT_FLAG_NS = 20; // select_to_flag_delay
   localparam int TOKEN_GAP_NS  = 15;  // token_read_gap
   localparam int TOKEN_ADDR_W  = 3;
   localparam int CNT_W         = 8;

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up

   localparam int SETTLE_NS = (MATCH_FLAG_NS > SELECT_FLAG_NS) ?
                              MATCH_FLAG_NS : SELECT_FLAG_NS;
   // settle time plus synchroniser depth: a busy raised at select must be
   // seen before the first strobe, or a contended write slips through
   localparam logic [CNT_W-1:0] SETTLE_CNT =
      CNT_W'(cyc_up(SETTLE_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] WRITE_CNT  = CNT_W'(cyc_up(WRITE_PULSE_NS));
   // read waits the access time plus the data synchroniser depth
   localparam logic [CNT_W-1:0] READ_CNT   =
      CNT_W'(cyc_up(ACCESS_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] GAP_CNT    = CNT_W'(cyc_up(TOKEN_GAP_NS));
   localparam logic [CNT_W-1:0] ONE_CNT    = 8'h01;

   // user command codes
   typedef enum logic [2:0] {
      OP_READ      = 3'h0,
      OP_WRITE     = 3'h1,
      OP_TOKEN_GET = 3'h2,
      OP_TOKEN_PUT = 3'h3,
      OP_MBOX_SEND = 3'h4,
      OP_MBOX_TAKE = 3'h5
   } dpm_op_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,
      S_SETUP  = 3'h1,
      S_STROBE = 3'h2,
      S_END    = 3'h3,
      S_GAP    = 3'h4
   } dpm_state_t;
endpackage : dpm_pkg

// two-flop synchroniser for pin inputs
module dpm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   // rst_val is XORed onto the output at all times: q reads rst_val in reset, and its set bits invert the data after
   assign q = sync_q ^ rst_val;
endmodule : dpm_sync

// ==== dpm_host.sv ====
// host controller driving one port of the dual-port memory
module dpm_host
   import dpm_pkg::*;
#(
   parameter int  ADDR_W   = 15,
   parameter int  DATA_W   = 16,
   parameter bit  IS_RIGHT = 1'b0
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire dpm_pkg::dpm_op_t  cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_wdata,
   input  wire logic [1:0]        cmd_be,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   rsp_busy_seen,
   output logic                   mbox_pending,
   output logic                   chip_select_n,
   output logic                   output_drive_n,
   output logic                   write_n,
   output logic                   token_latch_select_n,
   output logic                   high_byte_select_n,
   output logic                   low_byte_select_n,
   output logic [ADDR_W-1:0]      mem_addr,
   input  wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe_n,
   input  wire logic              busy_n,
   input  wire logic              interrupt_n
);
   import dpm_pkg::*;

   typedef struct packed {
      dpm_state_t        st;
      logic [CNT_W-1:0]  cnt;
      dpm_op_t           op;
      logic              rd_phase;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              sem_n;
      logic              ub_n;
      logic              lb_n;
      logic              dq_oe_n;
      logic              rsp_v;
      logic              busy_seen;
   } dpm_host_t;

   localparam logic [ADDR_W-1:0] TOP_ADDR = '1;
   localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);
   localparam logic [ADDR_W-1:0] OWN_MBOX =
      IS_RIGHT ? TOP_ADDR : TOP_ADDR - ADDR_ONE;
   localparam logic [ADDR_W-1:0] FAR_MBOX =
      IS_RIGHT ? TOP_ADDR - ADDR_ONE : TOP_ADDR;

   dpm_host_t q, d;
   logic [DATA_W-1:0] dq_sync;
   logic [1:0]        flags_sync;
   logic              busy_act;

   // token commands address the latches, never the array
   function automatic logic is_token(input dpm_op_t op);
      return (op == OP_TOKEN_GET) || (op == OP_TOKEN_PUT);
   endfunction : is_token

   // a token get writes first and reads afterwards
   function automatic logic is_write(input dpm_op_t op, input logic rd);
      case (op)
         OP_WRITE, OP_MBOX_SEND, OP_TOKEN_PUT: return 1'b1;
         OP_TOKEN_GET:                         return ~rd;
         default:                              return 1'b0;
      endcase
   endfunction : is_write

   // pin inputs cross into the clock domain before use
   dpm_sync #(.W(DATA_W)) u_dq_sync (
      .clk     (clk),
      .reset   (reset),
      .d       (data_in),
      .rst_val ('0),
      .q       (dq_sync)
   );

   // flags idle high, so sample them inverted and use them active high
   dpm_sync #(.W(2)) u_flag_sync (
      .clk     (clk),
      .reset   (reset),
      .d       ({~busy_n, ~interrupt_n}),
      .rst_val (2'h0),
      .q       (flags_sync)
   );

   assign busy_act = flags_sync[1];

   // next-state logic for the whole access sequence
   always_comb begin
      d       = q;
      d.rsp_v = 1'b0;
      case (q.st)
         S_IDLE: begin
            if (cmd_valid) begin
               d.op        = cmd_op;
               d.rd_phase  = 1'b0;
               d.busy_seen = 1'b0;
               d.we_n      = 1'b1;
               d.oe_n      = 1'b1;
               d.dq_oe_n   = 1'b1;
               d.wdata     = cmd_wdata;
               d.addr      = cmd_addr;
               d.ub_n      = ~cmd_be[1];
               d.lb_n      = ~cmd_be[0];
               if (is_token(cmd_op)) begin
                  // latch chosen by low address bits only
                  d.addr  = ADDR_W'(cmd_addr[TOKEN_ADDR_W-1:0]);
                  // value in bit zero, others follow for tidiness
                  d.wdata = {DATA_W{cmd_op == OP_TOKEN_PUT}};
                  d.ce_n  = 1'b1;
                  d.sem_n = 1'b0;
                  d.ub_n  = 1'b0;
                  d.lb_n  = 1'b0;
                  d.cnt   = ONE_CNT;
               end else begin
                  if (cmd_op == OP_MBOX_SEND) begin
                     d.addr = FAR_MBOX;
                  end else if (cmd_op == OP_MBOX_TAKE) begin
                     d.addr = OWN_MBOX;
                  end
                  d.ce_n  = 1'b0;
                  d.sem_n = 1'b1;
                  // busy needs the settle time after match or select
                  d.cnt   = SETTLE_CNT;
               end
               d.st = S_SETUP;
            end
         end
         S_SETUP: begin
            if (q.cnt > ONE_CNT) begin
               d.cnt = q.cnt - ONE_CNT;
            end else if (!is_token(q.op) && busy_act) begin
               // lost arbitration: hold off the strobe until busy clears
               d.busy_seen = 1'b1;
            end else if (is_write(q.op, q.rd_phase)) begin
               d.we_n    = 1'b0;
               d.dq_oe_n = 1'b0;
               d.cnt     = WRITE_CNT;
               d.st      = S_STROBE;
            end else begin
               d.oe_n = 1'b0;
               d.cnt  = READ_CNT;
               d.st   = S_STROBE;
            end
         end
         S_STROBE: begin
            if (q.cnt > ONE_CNT) begin
               d.cnt = q.cnt - ONE_CNT;
            end else if (!is_token(q.op) && busy_act) begin
               // blocked access, repeat it so a mailbox write or take lands
               d.we_n      = 1'b1;
               d.oe_n      = 1'b1;
               d.dq_oe_n   = 1'b1;
               d.busy_seen = 1'b1;
               d.cnt       = SETTLE_CNT;
               d.st        = S_SETUP;
            end else begin
               d.we_n = 1'b1;
               d.oe_n = 1'b1;
               if (!is_write(q.op, q.rd_phase)) begin
                  d.rdata = dq_sync;
               end
               d.st = S_END;
            end
         end
         S_END: begin
            // data stays driven one cycle past the write edge for hold
            d.ce_n    = 1'b1;
            d.sem_n   = 1'b1;
            d.dq_oe_n = 1'b1;
            if (q.op == OP_TOKEN_GET && (!q.rd_phase || q.rdata[0])) begin
               // one means the far side owns it: poll again
               d.rd_phase = 1'b1;
               d.cnt      = GAP_CNT;
               d.st       = S_GAP;
            end else begin
               d.rsp_v = 1'b1;
               d.st    = S_IDLE;
            end
         end
         S_GAP: begin
            // strobes stay released for the whole gap
            if (q.cnt > ONE_CNT) begin
               d.cnt = q.cnt - ONE_CNT;
            end else begin
               d.sem_n = 1'b0;
               d.cnt   = ONE_CNT;
               d.st    = S_SETUP;
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
   end

   // single state register
   always_ff @(posedge clk) begin
      if (reset) begin
         q.st        <= S_IDLE;
         q.cnt       <= '0;
         q.op        <= OP_READ;
         q.rd_phase  <= 1'b0;
         q.addr      <= '0;
         q.wdata     <= '0;
         q.rdata     <= '0;
         q.ce_n      <= 1'b1;
         q.oe_n      <= 1'b1;
         q.we_n      <= 1'b1;
         q.sem_n     <= 1'b1;
         q.ub_n      <= 1'b1;
         q.lb_n      <= 1'b1;
         q.dq_oe_n   <= 1'b1;
         q.rsp_v     <= 1'b0;
         q.busy_seen <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // pins and user outputs straight from the state register, mbox_pending from the flag synchroniser
   assign cmd_ready            = (q.st == S_IDLE);
   assign rsp_valid            = q.rsp_v;
   assign rsp_data             = q.rdata;
   assign rsp_busy_seen        = q.busy_seen;
   assign mbox_pending         = flags_sync[0];
   assign chip_select_n        = q.ce_n;
   assign output_drive_n       = q.oe_n;
   assign write_n              = q.we_n;
   assign token_latch_select_n = q.sem_n;
   assign high_byte_select_n   = q.ub_n;
   assign low_byte_select_n    = q.lb_n;
   assign mem_addr             = q.addr;
   assign data_out             = q.wdata;
   assign data_oe_n            = q.dq_oe_n;
endmodule : dpm_host

// ==== dpm_host_checker.sv ====
// pin sequencing checker for the dual-port memory host controller
module dpm_host_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic mbox_pending,
   input wire logic chip_select_n,
   input wire logic output_drive_n,
   input wire logic write_n,
   input wire logic token_latch_select_n,
   input wire logic data_oe_n,
   input wire logic busy_n,
   input wire logic interrupt_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // a token write must be followed by the select going away
   sequence s_tok_write;
      !token_latch_select_n && !write_n;
   endsequence
   sequence s_tok_off;
      ##[1:3] token_latch_select_n;
   endsequence
   a_select_excl: assert property (
      chip_select_n || token_latch_select_n) else $error("two selects low");
   a_read_gate: assert property (
      !output_drive_n |-> !chip_select_n || !token_latch_select_n)
      else $error("output enable without select");
   a_drive_clash: assert property (
      !data_oe_n |-> output_drive_n) else $error("bus driven during read");
   a_busy_hold: assert property (
      (!busy_n)[*5] ##0 token_latch_select_n |-> write_n)
      else $error("write strobe while busy");
   a_token_gap: assert property (
      s_tok_write |-> s_tok_off) else $error("no gap after token write");
   a_token_read: assert property (
      $fell(token_latch_select_n) |-> output_drive_n)
      else $error("token read with enable already low");
   a_pend_set: assert property (
      $fell(interrupt_n) |-> ##2 mbox_pending) else $error("pending late");
   a_pend_clear: assert property (
      $rose(interrupt_n) |-> ##2 !mbox_pending) else $error("pending stuck");
endmodule : dpm_host_checker

// ==== dpm_dev.sv ====
// behavioural model of the dual-port memory seen from the left port
module dpm_dev (
   input wire logic        clk,
   input wire logic        chip_select_n,
   input wire logic        output_drive_n,
   input wire logic        write_n,
   input wire logic        token_latch_select_n,
   input wire logic        high_byte_select_n,
   input wire logic        low_byte_select_n,
   input wire logic [14:0] mem_addr,
   input wire logic [15:0] data_out,
   input wire logic        busy_n,
   input wire logic        far_send,
   input wire logic        far_hold,
   output logic     [15:0] data_in,
   output logic            interrupt_n
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [14:0] BOX_R = 15'h7FFF;
   localparam logic [14:0] BOX_L = 15'h7FFE;
   logic [15:0] mem [0:32767];
   logic [1:0]  owner [0:7] = '{default: 2'h0}; // 1 left, 2 far
   logic [7:0]  pend_q = 8'h00;
   logic        int_l_q = 1'b0;
   logic        int_r_q = 1'b0;
   logic [15:0] last_q = 16'h0000;
   logic [15:0] rd = 16'h0000;
   logic [2:0]  idx;
   logic        drv;
   // writes land on the rising strobe, as in the real part
   always @(posedge write_n) begin
      idx = mem_addr[2:0];
      if (!chip_select_n) begin
         if (!low_byte_select_n) mem[mem_addr][7:0] = data_out[7:0];
         if (!high_byte_select_n) mem[mem_addr][15:8] = data_out[15:8];
         if (mem_addr == BOX_R && busy_n) int_r_q = 1'b1;
      end else if (!token_latch_select_n) begin
         if (data_out[0]) begin
            if (owner[idx] == 2'h1) owner[idx] = 2'h0;
            pend_q[idx] = 1'b0;
         end else if (owner[idx] == 2'h0) owner[idx] = 2'h1;
         else if (owner[idx] == 2'h2) pend_q[idx] = 1'b1;
      end
   end
   // far port claims token 0 while far_hold is high
   always @(far_hold) begin
      if (far_hold && owner[0] == 2'h0) owner[0] = 2'h2;
      else if (!far_hold && owner[0] == 2'h2) begin
         owner[0] = pend_q[0] ? 2'h1 : 2'h0;
         pend_q[0] = 1'b0;
      end
   end
   // far port posts a fixed message into the left mailbox
   always @(posedge far_send) begin
      mem[BOX_L] = 16'h00C3;
      int_l_q = 1'b1;
   end
   // value captured at enable, so far writes cannot disturb it
   always @(negedge output_drive_n) begin
      rd = !token_latch_select_n ? {16{owner[mem_addr[2:0]] != 2'h1}}
                                 : mem[mem_addr];
      if (!chip_select_n && mem_addr == BOX_L && busy_n)
         int_l_q = 1'b0;
   end
   // released bus shows the inverse of the last value, never a stale copy
   always @(posedge clk)
      if (drv) last_q <= rd;
   assign drv = !output_drive_n && (!chip_select_n || !token_latch_select_n);
   assign data_in = drv ? rd : ~last_q;
   assign interrupt_n = !int_l_q;
endmodule : dpm_dev

// ==== dpm_host_bench.sv ====
// self-checking bench for the host controller against the device model
module dpm_host_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import dpm_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        cmd_valid = 1'b0;
   logic        busy_n = 1'b1;
   logic        far_send = 1'b0;
   logic        far_hold = 1'b0;
   dpm_op_t     cmd_op = OP_READ;
   logic [14:0] cmd_addr = 15'h0000;
   logic [15:0] cmd_wdata = 16'h0000;
   logic [1:0]  cmd_be = 2'h3;
   logic        cmd_ready, rsp_valid, rsp_busy_seen, mbox_pending;
   logic        chip_select_n, output_drive_n, write_n, data_oe_n;
   logic        token_latch_select_n, interrupt_n;
   logic        high_byte_select_n, low_byte_select_n;
   logic [14:0] mem_addr;
   logic [15:0] rsp_data, data_in, data_out;
   int          mismatches = 0;
   int          samples_checked = 0;
   always #50 clk = ~clk;
   dpm_host #(.ADDR_W(15), .DATA_W(16), .IS_RIGHT(1'b0)) u_dpm_host (
      .clk(clk), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_be(cmd_be), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_busy_seen(rsp_busy_seen),
      .mbox_pending(mbox_pending), .chip_select_n(chip_select_n),
      .output_drive_n(output_drive_n), .write_n(write_n),
      .token_latch_select_n(token_latch_select_n),
      .high_byte_select_n(high_byte_select_n),
      .low_byte_select_n(low_byte_select_n), .mem_addr(mem_addr),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .busy_n(busy_n), .interrupt_n(interrupt_n));
   dpm_dev u_dpm_dev (
      .clk(clk), .chip_select_n(chip_select_n),
      .output_drive_n(output_drive_n), .write_n(write_n),
      .token_latch_select_n(token_latch_select_n),
      .high_byte_select_n(high_byte_select_n),
      .low_byte_select_n(low_byte_select_n), .mem_addr(mem_addr),
      .data_out(data_out), .busy_n(busy_n), .far_send(far_send),
      .far_hold(far_hold), .data_in(data_in), .interrupt_n(interrupt_n));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("mismatches %0d samples_checked %0d", mismatches,
               samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic stall(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : stall
   // bounded waits: a hang ends the run as a mismatch
   task automatic issue(input dpm_op_t op, input logic [14:0] a,
                        input logic [15:0] d, input logic [1:0] be);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin
         stall(1);
         n++;
      end
      if (cmd_ready !== 1'b1) begin
         mismatches++;
         $display("[ERR] %0t never ready", $time);
         give_verdict();
      end
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_be = be;
      cmd_valid = 1'b1;
      stall(1);
      cmd_valid = 1'b0;
   endtask : issue
   task automatic wait_rsp(input int lim);
      int n;
      n = 0;
      do begin
         stall(1);
         n++;
      end while (rsp_valid !== 1'b1 && n < lim);
      if (rsp_valid !== 1'b1) begin
         mismatches++;
         $display("[ERR] %0t no response", $time);
         give_verdict();
      end
   endtask : wait_rsp
   task automatic cmd(input dpm_op_t op, input logic [14:0] a,
                      input logic [15:0] d, input logic [1:0] be);
      issue(op, a, d, be);
      wait_rsp(60);
   endtask : cmd
   // byte lanes, and token latches kept apart from the array
   task automatic t_rw;
      cmd(OP_WRITE, 15'h0005, 16'h1234, 2'h3);
      cmd(OP_WRITE, 15'h0005, 16'h5A5A, 2'h1);
      cmd(OP_TOKEN_PUT, 15'h0005, 16'hFFFF, 2'h3);
      cmd(OP_READ, 15'h0005, 16'h0000, 2'h3);
      check(rsp_data, 16'h125A);
      check({15'h0000, rsp_busy_seen}, 16'h0000);
   endtask : t_rw
   task automatic t_mbox;
      far_send = 1'b1;
      stall(1);
      far_send = 1'b0;
      stall(4);
      check({15'h0000, mbox_pending}, 16'h0001);
      cmd(OP_MBOX_SEND, 15'h0000, 16'h0BEE, 2'h3);
      check(u_dpm_dev.mem[15'h7FFF], 16'h0BEE);
      check({15'h0000, u_dpm_dev.int_r_q}, 16'h0001);
      check({15'h0000, mbox_pending}, 16'h0001);
      cmd(OP_MBOX_TAKE, 15'h0000, 16'h0000, 2'h3);
      check(rsp_data, 16'h00C3);
      stall(4);
      check({15'h0000, mbox_pending}, 16'h0000);
   endtask : t_mbox
   // free token, then one held by the far side and handed over
   task automatic t_token;
      int n;
      cmd(OP_TOKEN_GET, 15'h7FFB, 16'h0000, 2'h3);
      check(rsp_data, 16'h0000);
      check({14'h0000, u_dpm_dev.owner[3]}, 16'h0001);
      cmd(OP_TOKEN_PUT, 15'h0003, 16'hFFFF, 2'h3);
      check({14'h0000, u_dpm_dev.owner[3]}, 16'h0000);
      far_hold = 1'b1;
      issue(OP_TOKEN_GET, 15'h0000, 16'h0000, 2'h3);
      n = 0;
      repeat (30) begin
         stall(1);
         if (rsp_valid !== 1'b0) n++;
      end
      check(16'(n), 16'h0000);
      far_hold = 1'b0;
      wait_rsp(60);
      check(rsp_data, 16'h0000);
      cmd(OP_TOKEN_PUT, 15'h0000, 16'hFFFF, 2'h3);
   endtask : t_token
   // a write must wait out busy and then complete
   task automatic t_busy;
      cmd(OP_WRITE, 15'h0009, 16'h0000, 2'h3);
      // bench acts as the master: far port granted, busy driven to us
      busy_n = 1'b0;
      issue(OP_WRITE, 15'h0009, 16'h7777, 2'h3);
      stall(10);
      check(u_dpm_dev.mem[15'h0009], 16'h0000);
      busy_n = 1'b1;
      wait_rsp(60);
      check(u_dpm_dev.mem[15'h0009], 16'h7777);
      check({15'h0000, rsp_busy_seen}, 16'h0001);
      // busy raised just after the select falls, inside the flag delay
      issue(OP_WRITE, 15'h0009, 16'h3C3C, 2'h3);
      busy_n = 1'b0;
      stall(10);
      check(u_dpm_dev.mem[15'h0009], 16'h7777);
      busy_n = 1'b1;
      wait_rsp(60);
      check(u_dpm_dev.mem[15'h0009], 16'h3C3C);
      check({15'h0000, rsp_busy_seen}, 16'h0001);
   endtask : t_busy
   initial begin
      stall(5);
      reset = 1'b0;
      t_rw();
      t_mbox();
      t_token();
      t_busy();
      give_verdict();
   end
endmodule : dpm_host_bench
bind dpm_host dpm_host_checker u_dpm_host_checker (
   .clk(clk), .reset(reset), .mbox_pending(mbox_pending),
   .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
   .write_n(write_n), .token_latch_select_n(token_latch_select_n),
   .data_oe_n(data_oe_n), .busy_n(busy_n), .interrupt_n(interrupt_n));
